// >>> logic/idp_port.sv
// Indirect parameter port: conduits, selector, parameter store, tone status.
// Assumes host accesses arrive as one-cycle strobes synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module idp_port (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire idp_pkg::idp_host_req_t host_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic on_hook,
  input wire logic command_mode,
  input wire logic dtmf_hit,
  input wire logic v23_hit,
  input wire logic [13:0] user_energy [4],
  input wire logic [13:0] progress_energy,
  input wire logic [13:0] carrier_level,
  input wire logic [13:0] answer_level,
  output idp_pkg::idp_params_t params,
  output logic [3:0] dtmf_digit,
  output logic [2:0] tone_type_field,
  output logic [13:0] gen_level,
  output logic [20:0] gen_freq_q2,
  output logic gen_user_tone,
  output logic square_enable,
  output logic cascade_disable,
  output logic progress_detect,
  output logic carrier_valid,
  output logic answer_valid,
  output logic write_refused
);
  logic [7:0] func_sel_reg;
  logic [15:0] param_addr_reg;
  logic [5:0] param_data_high_reg;
  logic [13:0] param_mem [idp_pkg::MEM_DEPTH];
  logic [7:0] tone_tx_control_reg;
  logic [7:0] detect_control_reg;
  logic data_avail_reg;
  logic [4:0] tone_type_reg;
  logic [4:0] tone_type_next;
  logic [3:0] user_hit;
  logic wr_low;
  logic wr_high;
  logic rd_low;
  logic addr_listed;
  logic commit;

  // Reset value of each parameter slot; unlisted slots read zero
  function automatic logic [13:0] default_of(input logic [15:0] a);
    logic [13:0] v;
    v = 14'h0000;
    if (a == idp_pkg::PA_TX_FULL) begin
      v = idp_pkg::RV_TX_FULL;
    end else if (a == idp_pkg::PA_DTMF_HIGH) begin
      v = idp_pkg::RV_DTMF_HIGH;
    end else if (a == idp_pkg::PA_DTMF_TWIST) begin
      v = idp_pkg::RV_DTMF_TWIST;
    end else if (a == idp_pkg::PA_USER_FREQ) begin
      v = idp_pkg::RV_USER_FREQ;
    end else if (a == idp_pkg::PA_PROGRESS) begin
      v = idp_pkg::RV_PROGRESS;
    end else if (a == idp_pkg::PA_UDET1 || a == idp_pkg::PA_UDET3) begin
      v = idp_pkg::RV_UDET_ODD;
    end else if (a == idp_pkg::PA_UDET2 || a == idp_pkg::PA_UDET4) begin
      v = idp_pkg::RV_UDET_EVEN;
    end else if (a == idp_pkg::PA_TONE_LEVEL) begin
      v = idp_pkg::RV_TONE_LEVEL;
    end else if (a == idp_pkg::PA_UDET_SENS) begin
      v = idp_pkg::RV_UDET_SENS;
    end else if (a == idp_pkg::PA_CAR_ON) begin
      v = idp_pkg::RV_CAR_ON;
    end else if (a == idp_pkg::PA_CAR_OFF) begin
      v = idp_pkg::RV_CAR_OFF;
    end else if (a == idp_pkg::PA_ANS_ON) begin
      v = idp_pkg::RV_ANS_ON;
    end else if (a == idp_pkg::PA_ANS_OFF) begin
      v = idp_pkg::RV_ANS_OFF;
    end
    return v;
  endfunction

  // True for the addresses the signal processor really decodes
  function automatic logic listed(input logic [15:0] a);
    return (a >= idp_pkg::PA_TX_FULL && a <= idp_pkg::PA_TONE_LEVEL) ||
           a == idp_pkg::PA_UDET_SENS ||
           (a >= idp_pkg::PA_CAR_ON && a <= idp_pkg::PA_ANS_OFF);
  endfunction

  // Host strobe decode
  assign wr_low = ce && host_req.wr && host_req.sreg == idp_pkg::SREG_CONDUIT_LOW;
  assign wr_high = ce && host_req.wr && host_req.sreg == idp_pkg::SREG_CONDUIT_HIGH;
  assign rd_low = ce && host_req.rd && host_req.sreg == idp_pkg::SREG_CONDUIT_LOW &&
                  func_sel_reg == idp_pkg::SEL_TONE;
  assign addr_listed = listed(param_addr_reg);
  assign commit = wr_low && func_sel_reg == idp_pkg::SEL_DATA;

  // Function selector register
  always_ff @(posedge clock) begin
    if (rst) begin
      func_sel_reg <= idp_pkg::FUNC_SEL_RESET;
    end else if (ce && host_req.wr && host_req.sreg == idp_pkg::SREG_FUNC_SEL) begin
      func_sel_reg <= host_req.wdata;
    end
  end

  // Address bytes, loaded in address mode
  always_ff @(posedge clock) begin
    if (rst) begin
      param_addr_reg <= 16'h0000;
    end else if (func_sel_reg == idp_pkg::SEL_ADDR) begin
      if (wr_low) begin
        param_addr_reg[7:0] <= host_req.wdata;
      end else if (wr_high) begin
        param_addr_reg[15:8] <= host_req.wdata;
      end
    end
  end

  // Upper data bits held until the low byte arrives
  always_ff @(posedge clock) begin
    if (rst) begin
      param_data_high_reg <= 6'h00;
    end else if (wr_high && func_sel_reg == idp_pkg::SEL_DATA) begin
      param_data_high_reg <= host_req.wdata[5:0];
    end
  end

  // Parameter store; commit only while on-hook in command mode
  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < idp_pkg::MEM_DEPTH; i++) begin
        param_mem[i] <= default_of(16'(i));
      end
    end else if (commit && on_hook && command_mode && addr_listed) begin
      param_mem[param_addr_reg[5:0]] <= {param_data_high_reg, host_req.wdata};
    end
  end

  // Sticky flag for commits dropped by line state or bad address
  always_ff @(posedge clock) begin
    if (rst) begin
      write_refused <= 1'b0;
    end else if (commit && !(on_hook && command_mode && addr_listed)) begin
      write_refused <= 1'b1;
    end else if (ce && host_req.wr && host_req.sreg == idp_pkg::SREG_FUNC_SEL) begin
      write_refused <= 1'b0;
    end
  end

  // Tone transmit and detect control bytes
  always_ff @(posedge clock) begin
    if (rst) begin
      tone_tx_control_reg <= 8'h00;
      detect_control_reg <= 8'h00;
    end else if (func_sel_reg == idp_pkg::SEL_TONE) begin
      if (wr_low) begin
        tone_tx_control_reg <= {1'b0, host_req.wdata[6:0]};
      end else if (wr_high) begin
        detect_control_reg <= {host_req.wdata[7:6], 1'b0, host_req.wdata[4:0]};
      end
    end
  end

  // Parameter views for the signal path
  assign params.tx_full_scale_level = param_mem[idp_pkg::PA_TX_FULL[5:0]];
  assign params.dtmf_high_tone_level = param_mem[idp_pkg::PA_DTMF_HIGH[5:0]];
  assign params.dtmf_twist_ratio = param_mem[idp_pkg::PA_DTMF_TWIST[5:0]];
  assign params.user_tx_tone_freq = param_mem[idp_pkg::PA_USER_FREQ[5:0]];
  assign params.progress_detect_level = param_mem[idp_pkg::PA_PROGRESS[5:0]];
  assign params.user_detector_1_center = param_mem[idp_pkg::PA_UDET1[5:0]];
  assign params.user_detector_2_center = param_mem[idp_pkg::PA_UDET2[5:0]];
  assign params.user_detector_3_center = param_mem[idp_pkg::PA_UDET3[5:0]];
  assign params.user_detector_4_center = param_mem[idp_pkg::PA_UDET4[5:0]];
  assign params.tone_gen_level = param_mem[idp_pkg::PA_TONE_LEVEL[5:0]];
  assign params.user_detector_sensitivity = param_mem[idp_pkg::PA_UDET_SENS[5:0]];

  // Tone generator settings
  assign tone_type_field = tone_tx_control_reg[2:0];
  assign dtmf_digit = tone_tx_control_reg[6:3];
  assign square_enable = detect_control_reg[idp_pkg::DC_SQUARE];
  assign cascade_disable = detect_control_reg[idp_pkg::DC_NOCASCADE];

  // Generated amplitude and user tone frequency in quarter hertz
  always_ff @(posedge clock) begin
    if (rst) begin
      gen_level <= 14'h0000;
      gen_freq_q2 <= 21'h00_0000;
      gen_user_tone <= 1'b0;
    end else if (ce) begin
      gen_level <= params.tone_gen_level;
      gen_user_tone <= tone_type_field == idp_pkg::TONE_USER;
      gen_freq_q2 <= 21'(params.user_tx_tone_freq) * 21'(idp_pkg::FREQ_STEP_Q2);
    end
  end

  // Call progress energy against its threshold
  always_ff @(posedge clock) begin
    if (rst) begin
      progress_detect <= 1'b0;
    end else if (ce) begin
      progress_detect <= progress_energy >= params.progress_detect_level;
    end
  end

  // User detectors share one sensitivity threshold
  always_comb begin
    user_hit = 4'h0;
    for (int k = 0; k < 4; k++) begin
      user_hit[k] = user_energy[k] >= params.user_detector_sensitivity;
    end
  end

  // Priority encode the enabled detections
  always_comb begin
    tone_type_next = idp_pkg::TT_NONE;
    if (detect_control_reg[1] && answer_valid) begin
      tone_type_next = idp_pkg::TT_ANSWER;
    end else if (detect_control_reg[2] && v23_hit) begin
      tone_type_next = idp_pkg::TT_V23;
    end else if (detect_control_reg[0] && dtmf_hit) begin
      tone_type_next = idp_pkg::TT_DTMF;
    end else if (detect_control_reg[3] && user_hit[0]) begin
      tone_type_next = idp_pkg::TT_USER1;
    end else if (detect_control_reg[3] && user_hit[1]) begin
      tone_type_next = idp_pkg::TT_USER1 + 5'h01;
    end else if (detect_control_reg[4] && user_hit[2]) begin
      tone_type_next = idp_pkg::TT_USER1 + 5'h02;
    end else if (detect_control_reg[4] && user_hit[3]) begin
      tone_type_next = idp_pkg::TT_USER1 + 5'h03;
    end
  end

  // Latest result and its availability; a new result beats a read clear
  always_ff @(posedge clock) begin
    if (rst) begin
      tone_type_reg <= idp_pkg::TT_NONE;
      data_avail_reg <= 1'b0;
    end else if (ce) begin
      tone_type_reg <= tone_type_next;
      if (tone_type_next != tone_type_reg) begin
        data_avail_reg <= 1'b1;
      end else if (rd_low) begin
        data_avail_reg <= 1'b0;
      end
    end
  end

  // Read answer, one cycle after the strobe
  always_ff @(posedge clock) begin
    if (rst) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else if (ce) begin
      rd_valid <= host_req.rd;
      if (host_req.rd && host_req.sreg == idp_pkg::SREG_FUNC_SEL) begin
        rd_data <= func_sel_reg;
      end else if (rd_low) begin
        rd_data <= {data_avail_reg, tone_type_reg != idp_pkg::TT_NONE, 1'b0,
                    tone_type_reg};
      end else begin
        rd_data <= 8'h00;
      end
    end else begin
      rd_valid <= 1'b0;
    end
  end

  // Carrier and answer level detectors
  idp_hyst u_carrier (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .level(carrier_level),
    .on_thr(param_mem[idp_pkg::PA_CAR_ON[5:0]]),
    .off_thr(param_mem[idp_pkg::PA_CAR_OFF[5:0]]),
    .valid(carrier_valid)
  );
  idp_hyst u_answer (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .level(answer_level),
    .on_thr(param_mem[idp_pkg::PA_ANS_ON[5:0]]),
    .off_thr(param_mem[idp_pkg::PA_ANS_OFF[5:0]]),
    .valid(answer_valid)
  );

  chk_addr_low_load: assert property (@(posedge clock) disable iff (rst)
    (wr_low && func_sel_reg == idp_pkg::SEL_ADDR) |=>
    param_addr_reg[7:0] == $past(host_req.wdata))
    else $error("address low byte not loaded");
  chk_addr_high_load: assert property (@(posedge clock) disable iff (rst)
    (wr_high && func_sel_reg == idp_pkg::SEL_ADDR) |=>
    param_addr_reg[15:8] == $past(host_req.wdata) && $stable(param_addr_reg[7:0]))
    else $error("address high byte not loaded");
  chk_data_high_six: assert property (@(posedge clock) disable iff (rst)
    (wr_high && func_sel_reg == idp_pkg::SEL_DATA) |=>
    param_data_high_reg == $past(host_req.wdata[5:0]) && $stable(param_addr_reg))
    else $error("data high bits not held");
  chk_data_commit: assert property (@(posedge clock) disable iff (rst)
    (commit && on_hook && command_mode && addr_listed) |=>
    param_mem[$past(param_addr_reg[5:0])] == {$past(param_data_high_reg),
    $past(host_req.wdata)})
    else $error("data word not committed to addressed parameter");
  chk_status_read: assert property (@(posedge clock) disable iff (rst)
    rd_low |=> rd_valid && rd_data[4:0] == $past(tone_type_reg) && !rd_data[5] &&
    rd_data[idp_pkg::ST_DETECT] == ($past(tone_type_reg) != idp_pkg::TT_NONE) &&
    rd_data[idp_pkg::ST_AVAIL] == $past(data_avail_reg))
    else $error("tone status read wrong");
  chk_prio_answer: assert property (@(posedge clock) disable iff (rst)
    (ce && detect_control_reg[1] && answer_valid) |=>
    tone_type_reg == idp_pkg::TT_ANSWER)
    else $error("answer tone not reported first");
  chk_user_freq: assert property (@(posedge clock) disable iff (rst)
    (ce && tone_type_field == idp_pkg::TONE_USER) |=> gen_user_tone &&
    gen_freq_q2 == 21'($past(params.user_tx_tone_freq)) * 21'(idp_pkg::FREQ_STEP_Q2))
    else $error("user tone frequency wrong");
  chk_tone_ctrl_write: assert property (@(posedge clock) disable iff (rst)
    (wr_low && func_sel_reg == idp_pkg::SEL_TONE) |=>
    tone_type_field == $past(host_req.wdata[2:0]) &&
    dtmf_digit == $past(host_req.wdata[6:3]))
    else $error("tone control byte not applied");
  chk_refuse_flag: assert property (@(posedge clock) disable iff (rst)
    (commit && !(on_hook && command_mode && addr_listed)) |=>
    write_refused && $stable(params))
    else $error("refused commit not flagged or store changed");
  chk_freeze_hold: assert property (@(posedge clock) disable iff (rst)
    !ce |=> $stable(func_sel_reg) && $stable(param_addr_reg) && !rd_valid)
    else $error("state moved while clock enable low");
  chk_detect_ctrl_write: assert property (@(posedge clock) disable iff (rst)
    (wr_high && func_sel_reg == idp_pkg::SEL_TONE) |=> !detect_control_reg[5] &&
    square_enable == $past(host_req.wdata[idp_pkg::DC_SQUARE]) &&
    cascade_disable == $past(host_req.wdata[idp_pkg::DC_NOCASCADE]))
    else $error("detect control byte not applied");
  chk_progress_level: assert property (@(posedge clock) disable iff (rst)
    ce |=> progress_detect == ($past(progress_energy) >= $past(params.progress_detect_level)))
    else $error("progress detect disagrees with threshold");
  chk_gen_level: assert property (@(posedge clock) disable iff (rst)
    ce |=> gen_level == $past(params.tone_gen_level))
    else $error("tone generation level not passed on");
  chk_avail_set: assert property (@(posedge clock) disable iff (rst)
    (ce && tone_type_next != tone_type_reg) |=> data_avail_reg)
    else $error("data available not raised on new result");
endmodule
`default_nettype wire

// >>> logic/idp_pkg.sv
// Constants and carriers for the indirect parameter port.
// Assumes one system clock and a synchronous active-high reset.
package idp_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 14;
  localparam int MEM_DEPTH = 40;
  // Host-side register numbers of the two conduit registers and the function selector
  localparam logic [7:0] SREG_CONDUIT_LOW = 8'hE5;
  localparam logic [7:0] SREG_CONDUIT_HIGH = 8'hE6;
  localparam logic [7:0] SREG_FUNC_SEL = 8'hE8;
  localparam logic [7:0] FUNC_SEL_RESET = 8'h00;
  // Function selector codes
  localparam logic [7:0] SEL_ADDR = 8'h00;
  localparam logic [7:0] SEL_DATA = 8'h01;
  localparam logic [7:0] SEL_TONE = 8'h02;
  // Parameter addresses
  localparam logic [15:0] PA_TX_FULL = 16'h0002;
  localparam logic [15:0] PA_DTMF_HIGH = 16'h0003;
  localparam logic [15:0] PA_DTMF_TWIST = 16'h0004;
  localparam logic [15:0] PA_USER_FREQ = 16'h0005;
  localparam logic [15:0] PA_PROGRESS = 16'h0006;
  localparam logic [15:0] PA_UDET1 = 16'h0007;
  localparam logic [15:0] PA_UDET2 = 16'h0008;
  localparam logic [15:0] PA_UDET3 = 16'h0009;
  localparam logic [15:0] PA_UDET4 = 16'h000A;
  localparam logic [15:0] PA_TONE_LEVEL = 16'h000B;
  localparam logic [15:0] PA_UDET_SENS = 16'h000E;
  localparam logic [15:0] PA_CAR_ON = 16'h0024;
  localparam logic [15:0] PA_CAR_OFF = 16'h0025;
  localparam logic [15:0] PA_ANS_ON = 16'h0026;
  localparam logic [15:0] PA_ANS_OFF = 16'h0027;
  // Parameter reset values
  localparam logic [13:0] RV_TX_FULL = 14'h1000;
  localparam logic [13:0] RV_DTMF_HIGH = 14'h1304;
  localparam logic [13:0] RV_DTMF_TWIST = 14'h0CCD;
  localparam logic [13:0] RV_USER_FREQ = 14'h005B;
  localparam logic [13:0] RV_PROGRESS = 14'h1000;
  localparam logic [13:0] RV_UDET_ODD = 14'h137B;
  localparam logic [13:0] RV_UDET_EVEN = 14'h0218;
  localparam logic [13:0] RV_TONE_LEVEL = 14'h0B50;
  localparam logic [13:0] RV_UDET_SENS = 14'h1000;
  localparam logic [13:0] RV_CAR_ON = 14'h0A3C;
  localparam logic [13:0] RV_CAR_OFF = 14'h0CE4;
  localparam logic [13:0] RV_ANS_ON = 14'h0043;
  localparam logic [13:0] RV_ANS_OFF = 14'h0025;
  // Step of 9600/512 Hz is 75 quarter-hertz
  localparam logic [6:0] FREQ_STEP_Q2 = 7'h4B;
  localparam logic [2:0] TONE_USER = 3'b110;
  // Status byte bit positions
  localparam int ST_AVAIL = 7;
  localparam int ST_DETECT = 6;
  // Detect control bit positions
  localparam int DC_SQUARE = 7;
  localparam int DC_NOCASCADE = 6;
  // Reported tone type codes
  localparam logic [4:0] TT_NONE = 5'h00;
  localparam logic [4:0] TT_ANSWER = 5'h01;
  localparam logic [4:0] TT_V23 = 5'h02;
  localparam logic [4:0] TT_DTMF = 5'h03;
  localparam logic [4:0] TT_USER1 = 5'h04;

  // Host access to one register number
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] sreg;
    logic [7:0] wdata;
  } idp_host_req_t;

  // Live parameter values handed to the signal path
  typedef struct packed {
    logic [13:0] tx_full_scale_level;
    logic [13:0] dtmf_high_tone_level;
    logic [13:0] dtmf_twist_ratio;
    logic [13:0] user_tx_tone_freq;
    logic [13:0] progress_detect_level;
    logic [13:0] user_detector_1_center;
    logic [13:0] user_detector_2_center;
    logic [13:0] user_detector_3_center;
    logic [13:0] user_detector_4_center;
    logic [13:0] tone_gen_level;
    logic [13:0] user_detector_sensitivity;
  } idp_params_t;
endpackage

// >>> logic/idp_hyst.sv
// Level detector with separate on and off thresholds.
// Assumes level samples are synchronous to the clock.
`timescale 1ns/1ps
`default_nettype none
module idp_hyst (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [13:0] level,
  input wire logic [13:0] on_thr,
  input wire logic [13:0] off_thr,
  output logic valid
);
  // Turns on at on level, off only below off level
  always_ff @(posedge clock) begin
    if (rst) begin
      valid <= 1'b0;
    end else if (ce) begin
      if (!valid && level >= on_thr) begin
        valid <= 1'b1;
      end else if (valid && level < off_thr) begin
        valid <= 1'b0;
      end
    end
  end

  chk_hyst_turn_on: assert property (@(posedge clock) disable iff (rst)
    (ce && !valid && level >= on_thr) |=> valid)
    else $error("level detector missed on threshold");
  chk_hyst_turn_off: assert property (@(posedge clock) disable iff (rst)
    (ce && valid && level < off_thr) |=> !valid)
    else $error("level detector missed off threshold");
endmodule
`default_nettype wire

// >>> verification/idp_host_model.sv
// Host model: issues register accesses to the parameter port, one strobe at a time.
// Assumes the port takes a strobe on the edge after it is raised and answers reads a cycle later.
`timescale 1ns/1ps
`default_nettype none
module idp_host_model (
  input wire logic clock,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  output var idp_pkg::idp_host_req_t host_req
);
  // Idle request from time zero
  initial host_req = '0;

  // One-cycle write strobe to one register number
  task automatic wr(input logic [7:0] sreg, input logic [7:0] data);
    @(posedge clock);
    host_req <= {1'b1, 1'b0, sreg, data};
    @(posedge clock);
    host_req <= '0;
  endtask

  // One-cycle read strobe, then a bounded wait for the answer
  task automatic rd(input logic [7:0] sreg, output logic [7:0] data, output logic ok);
    @(posedge clock);
    host_req <= {1'b0, 1'b1, sreg, 8'h00};
    @(posedge clock);
    host_req <= '0;
    ok = 1'b0;
    data = 8'h00;
    for (int n = 0; n < 4 && !ok; n++) begin
      #1;
      if (rd_valid === 1'b1) begin
        data = rd_data;
        ok = 1'b1;
      end else begin
        @(posedge clock);
      end
    end
  endtask

  // Address first, then high data byte; the low byte commits the word
  task automatic param_write(input logic [15:0] addr, input logic [13:0] data);
    wr(idp_pkg::SREG_FUNC_SEL, idp_pkg::SEL_ADDR);
    wr(idp_pkg::SREG_CONDUIT_HIGH, addr[15:8]);
    wr(idp_pkg::SREG_CONDUIT_LOW, addr[7:0]);
    wr(idp_pkg::SREG_FUNC_SEL, idp_pkg::SEL_DATA);
    wr(idp_pkg::SREG_CONDUIT_HIGH, {2'b00, data[13:8]});
    wr(idp_pkg::SREG_CONDUIT_LOW, data[7:0]);
  endtask
endmodule
`default_nettype wire

// >>> verification/indirect_dsp_register_port_tb_top.sv
// Self-checking bench for the indirect parameter port, host side driven by the host model.
// Assumes the design files and package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module indirect_dsp_register_port_tb_top;
  logic clock, rst, ce, on_hook, command_mode, dtmf_hit, v23_hit;
  logic [13:0] user_energy [4];
  logic [13:0] progress_energy, carrier_level, answer_level;
  idp_pkg::idp_host_req_t host_req;
  idp_pkg::idp_params_t params;
  logic [7:0] rd_data, d;
  logic rd_valid, ok, gen_user_tone, square_enable, cascade_disable;
  logic progress_detect, carrier_valid, answer_valid, write_refused;
  logic [3:0] dtmf_digit;
  logic [2:0] tone_type_field;
  logic [13:0] gen_level;
  logic [20:0] gen_freq_q2;
  logic [153:0] exp_p;
  int failures = 0;
  int n_compared = 0;
  logic [15:0] pa [11] = '{idp_pkg::PA_TX_FULL, idp_pkg::PA_DTMF_HIGH, idp_pkg::PA_DTMF_TWIST,
    idp_pkg::PA_USER_FREQ, idp_pkg::PA_PROGRESS, idp_pkg::PA_UDET1, idp_pkg::PA_UDET2,
    idp_pkg::PA_UDET3, idp_pkg::PA_UDET4, idp_pkg::PA_TONE_LEVEL, idp_pkg::PA_UDET_SENS};

  idp_port i_idp_port (.clock(clock), .rst(rst), .ce(ce), .host_req(host_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .on_hook(on_hook), .command_mode(command_mode),
    .dtmf_hit(dtmf_hit), .v23_hit(v23_hit), .user_energy(user_energy),
    .progress_energy(progress_energy), .carrier_level(carrier_level),
    .answer_level(answer_level), .params(params), .dtmf_digit(dtmf_digit),
    .tone_type_field(tone_type_field), .gen_level(gen_level), .gen_freq_q2(gen_freq_q2),
    .gen_user_tone(gen_user_tone), .square_enable(square_enable),
    .cascade_disable(cascade_disable), .progress_detect(progress_detect),
    .carrier_valid(carrier_valid), .answer_valid(answer_valid), .write_refused(write_refused));

  idp_host_model i_idp_host_model (.clock(clock), .rd_data(rd_data), .rd_valid(rd_valid),
    .host_req(host_req));

  // Free-running 4 ns clock
  always #2 clock = ~clock;

  // Distinct test value for parameter slot i
  function automatic logic [13:0] pval(input int i);
    return 14'h2001 + 14'(i) * 14'h0123;
  endfunction

  task automatic check(input string name, input logic [159:0] seen, input logic [159:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic summarize;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic settle;
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [7:0] sreg, input logic [7:0] data);
    i_idp_host_model.wr(sreg, data);
  endtask

  // Read with a timeout that ends the run
  task automatic rd_expect(input string name, input logic [7:0] sreg, input logic [7:0] exp);
    i_idp_host_model.rd(sreg, d, ok);
    if (!ok) begin
      failures++;
      summarize();
    end else begin
      check(name, d, exp);
    end
  endtask

  // Each of the eleven parameters in the params view written back to back, then that view compared
  task automatic t_params;
    for (int i = 0; i < 11; i++) begin
      i_idp_host_model.param_write(pa[i], pval(i));
      exp_p[(10 - i) * 14 +: 14] = pval(i);
    end
    settle();
    check("params", params, exp_p);
    check("gen_freq_q2", gen_freq_q2, 21'(pval(3)) * 21'd75);
  endtask

  // Off-hook, data mode and unlisted address commits are dropped and flagged
  task automatic t_refuse;
    for (int k = 0; k < 3; k++) begin
      @(posedge clock);
      on_hook <= (k != 0);
      command_mode <= (k != 1);
      i_idp_host_model.param_write((k == 2) ? 16'h0015 : idp_pkg::PA_TX_FULL, 14'h0001);
      settle();
      check("params_kept", params, exp_p);
      check("refused", write_refused, 1'b1);
      wr(idp_pkg::SREG_FUNC_SEL, idp_pkg::SEL_ADDR);
      settle();
      check("refused_clear", write_refused, 1'b0);
    end
    on_hook <= 1'b1;
    command_mode <= 1'b1;
  endtask

  // Tone transmit and detect control views, reserved bits set
  task automatic t_tone;
    wr(idp_pkg::SREG_FUNC_SEL, idp_pkg::SEL_TONE);
    wr(idp_pkg::SREG_CONDUIT_LOW, 8'hD6);
    settle();
    check("digit", dtmf_digit, 4'hA);
    check("tone_type", tone_type_field, idp_pkg::TONE_USER);
    check("user_tone", gen_user_tone, 1'b1);
    check("gen_level", gen_level, pval(9));
    wr(idp_pkg::SREG_CONDUIT_LOW, 8'h01);
    wr(idp_pkg::SREG_CONDUIT_HIGH, 8'hE0);
    settle();
    check("user_tone_off", gen_user_tone, 1'b0);
    check("square", square_enable, 1'b1);
    check("cascade", cascade_disable, 1'b1);
    wr(idp_pkg::SREG_CONDUIT_HIGH, 8'h40);
    settle();
    check("square_off", square_enable, 1'b0);
  endtask

  // Status readout, priority among enabled detections, read-only views
  task automatic t_status;
    wr(idp_pkg::SREG_CONDUIT_HIGH, 8'h1F);
    @(posedge clock);
    dtmf_hit <= 1'b1;
    v23_hit <= 1'b1;
    settle();
    rd_expect("status_v23", idp_pkg::SREG_CONDUIT_LOW, 8'hC2);
    rd_expect("status_again", idp_pkg::SREG_CONDUIT_LOW, 8'h42);
    wr(idp_pkg::SREG_CONDUIT_HIGH, 8'h1B);
    settle();
    rd_expect("status_dtmf", idp_pkg::SREG_CONDUIT_LOW, 8'hC3);
    wr(idp_pkg::SREG_CONDUIT_HIGH, 8'h08);
    @(posedge clock);
    user_energy[0] <= 14'h3FFF;
    settle();
    rd_expect("status_user", idp_pkg::SREG_CONDUIT_LOW, 8'hC4);
    rd_expect("high_read", idp_pkg::SREG_CONDUIT_HIGH, 8'h00);
    wr(idp_pkg::SREG_FUNC_SEL, idp_pkg::SEL_ADDR);
    rd_expect("addr_view_read", idp_pkg::SREG_CONDUIT_LOW, 8'h00);
  endtask

  // Hysteresis of carrier and answer detection, progress energy threshold
  task automatic t_levels;
    logic [13:0] lv [4] = '{14'h01FF, 14'h0200, 14'h0100, 14'h00FF};
    logic ev [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    i_idp_host_model.param_write(idp_pkg::PA_CAR_ON, 14'h0200);
    i_idp_host_model.param_write(idp_pkg::PA_CAR_OFF, 14'h0100);
    i_idp_host_model.param_write(idp_pkg::PA_ANS_ON, 14'h0200);
    i_idp_host_model.param_write(idp_pkg::PA_ANS_OFF, 14'h0100);
    wr(idp_pkg::SREG_FUNC_SEL, idp_pkg::SEL_TONE);
    wr(idp_pkg::SREG_CONDUIT_HIGH, 8'h02);
    for (int k = 0; k < 4; k++) begin
      @(posedge clock);
      carrier_level <= lv[k];
      answer_level <= lv[k];
      progress_energy <= pval(4) - 14'(k % 2);
      settle();
      check("carrier", carrier_valid, ev[k]);
      check("answer", answer_valid, ev[k]);
      check("progress", progress_detect, (k % 2) == 0);
      if (k == 1) begin
        rd_expect("status_answer", idp_pkg::SREG_CONDUIT_LOW, 8'hC1);
      end
    end
  endtask

  // Clock enable low: a selector write is ignored
  task automatic t_freeze;
    @(posedge clock);
    ce <= 1'b0;
    wr(idp_pkg::SREG_FUNC_SEL, idp_pkg::SEL_DATA);
    @(posedge clock);
    ce <= 1'b1;
    rd_expect("sel_frozen", idp_pkg::SREG_FUNC_SEL, idp_pkg::SEL_TONE);
  endtask

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    summarize();
  end

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    ce = 1'b1;
    on_hook = 1'b1;
    command_mode = 1'b1;
    dtmf_hit = 1'b0;
    v23_hit = 1'b0;
    for (int i = 0; i < 4; i++) user_energy[i] = 14'h0000;
    progress_energy = 14'h0000;
    carrier_level = 14'h0000;
    answer_level = 14'h0000;
    exp_p = {idp_pkg::RV_TX_FULL, idp_pkg::RV_DTMF_HIGH, idp_pkg::RV_DTMF_TWIST,
      idp_pkg::RV_USER_FREQ, idp_pkg::RV_PROGRESS, idp_pkg::RV_UDET_ODD, idp_pkg::RV_UDET_EVEN,
      idp_pkg::RV_UDET_ODD, idp_pkg::RV_UDET_EVEN, idp_pkg::RV_TONE_LEVEL, idp_pkg::RV_UDET_SENS};
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    check("reset_params", params, exp_p);
    check("reset_refused", write_refused, 1'b0);
    t_params();
    t_refuse();
    t_tone();
    t_status();
    t_levels();
    t_freeze();
    summarize();
  end
endmodule
`default_nettype wire
